// ==== pkg/pba_pkg.sv ====
package pba_pkg;
  // Requestor count and indices: 0..6 external, 7 is the bridge's own master
  localparam int unsigned NUM_REQ    = 8;
  localparam int unsigned NUM_EXT    = 7;
  localparam int unsigned BRIDGE_IDX = 7;

  // Priority scheme codes
  localparam logic [1:0] SCHEME_FIXED = 2'h0;
  localparam logic [1:0] SCHEME_RR    = 2'h1;
  localparam logic [1:0] SCHEME_MIXED = 2'h2;
  localparam logic [1:0] SCHEME_RST   = SCHEME_FIXED;

  // Order field reset value
  localparam logic [2:0] ORDER_RST = 3'h0;

  // Parking codes
  localparam logic [3:0] PARK_LAST   = 4'h0;
  localparam logic [3:0] PARK_BRIDGE = 4'h8;
  localparam logic [3:0] PARK_NONE   = 4'hf;
  localparam logic [3:0] PARK_RST    = PARK_BRIDGE;

  // Grant engine states
  typedef enum logic [2:0] {
    PBA_IDLE  = 3'b001,
    PBA_GRANT = 3'b010,
    PBA_LOCK  = 3'b100
  } pba_state_t;
endpackage

// ==== design/pba_pick.sv ====
`timescale 1ns/1ps
// Combinational winner selection for all three schemes
module pba_pick #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0] req,
  input  wire logic [1:0]   scheme,
  input  wire logic [2:0]   order,
  input  wire logic [2:0]   last,
  input  wire logic [3:0]   pair_last,
  output logic              any,
  output logic [2:0]        win
);
  // Fixed rank: position k holds requestor (6 - k + order) mod 8 (7 = bridge)
  function automatic logic [2:0] fixed_at(input logic [2:0] ord, input logic [2:0] k);
    fixed_at = 3'h6 - k + ord;
  endfunction

  logic [2:0] fix_w;
  logic [2:0] rr_w;
  logic [2:0] mix_w;
  logic       f_hit;
  logic       r_hit;
  logic       m_hit;
  logic [2:0] idx;
  logic [1:0] grp;
  logic [2:0] hi;
  logic [2:0] lo;

  // Scan candidate lists; first hit wins
  always_comb begin
    fix_w = 3'h0;
    rr_w  = 3'h0;
    mix_w = 3'h0;
    f_hit = 1'b0;
    r_hit = 1'b0;
    m_hit = 1'b0;
    idx   = 3'h0;
    grp   = 2'h0;
    hi    = 3'h0;
    lo    = 3'h0;
    for (int k = 0; k < 8; k++) begin
      idx = fixed_at(order, 3'(k));
      if (!f_hit && req[idx]) begin
        f_hit = 1'b1;
        fix_w = idx;
      end
      idx = last - 3'(k) - 3'h1;
      if (!r_hit && req[idx]) begin
        r_hit = 1'b1;
        rr_w  = idx;
      end
    end
    // Group g holds requestors 6-2g and 5-2g (group 3 = 0 and bridge)
    for (int k = 0; k < 4; k++) begin
      grp = 2'(k) - order[1:0];
      hi  = 3'h6 - {grp, 1'b0};
      lo  = hi - 3'h1;
      if (!m_hit && (req[hi] || req[lo])) begin
        m_hit = 1'b1;
        // Alternate within the pair: the member not served last goes first
        if (req[hi] && req[lo]) begin
          mix_w = pair_last[grp] ? lo : hi;
        end else begin
          mix_w = req[hi] ? hi : lo;
        end
      end
    end
  end

  assign any = |req;
  assign win = (scheme == pba_pkg::SCHEME_RR)    ? rr_w :
               (scheme == pba_pkg::SCHEME_MIXED) ? mix_w : fix_w;
endmodule // pba_pick

// ==== design/pba_arbiter.sv ====
`timescale 1ns/1ps
// Operation
// - Eight requestors: bridge master plus seven external request/grant pairs.
// - Arbiter enable is a strap sampled at reset; high enables.
// - Disabled: pin 0 becomes bridge grant in/request out; grants float in reset.
// - Scheme selects fixed, round robin or mixed; fixed after reset.
// - Fixed order 000 ranks 6..0 then bridge; each step rotates one place.
// - Order field resets to 000.
// - Round robin rotates fairly and ignores the order field.
// - Mixed groups: 6/5, 4/3, 2/1, 0/bridge.
// - Mixed: round robin within group, fixed priority among groups.
// - Mixed group order rotates with order field values 000 to 011.
// - Park code: 0 last, 1-7 requestor 6..0, 8 bridge, f none.
// - Park field resets to bridge.
// - Hold-on-lock keeps the locking agent's grant until lock releases and the bus is idle.
// - Without hold-on-lock, locked cycles arbitrate as normal ones.
module pba_arbiter #(
  parameter int unsigned NUM_EXT = pba_pkg::NUM_EXT
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               strap_enable,
  input  wire logic [1:0]         priority_scheme_sel,
  input  wire logic [2:0]         priority_order_sel,
  input  wire logic [3:0]         park_target_sel,
  input  wire logic               hold_grant_on_lock,
  input  wire logic [NUM_EXT-1:0] ext_request_in_n,
  output logic      [NUM_EXT-1:0] ext_grant_out_n,
  output logic      [NUM_EXT-1:0] ext_grant_oe,
  input  wire logic               bridge_req,
  output logic                    bridge_gnt,
  input  wire logic               frame_n,
  input  wire logic               irdy_n,
  input  wire logic               lock_n,
  output logic                    arb_enabled
);
  logic                   en_reg;
  logic                   seen_reg;
  logic [1:0]             scheme_reg;
  logic [2:0]             order_reg;
  logic [3:0]             park_reg;
  logic [1:0]             scheme_next;
  logic [2:0]             order_next;
  logic [3:0]             park_next;
  pba_pkg::pba_state_t    state_reg;
  pba_pkg::pba_state_t    state_next;
  logic [2:0]             owner_reg;
  logic [2:0]             owner_next;
  logic                   gnt_valid_reg;
  logic                   gnt_valid_next;
  logic [2:0]             last_reg;
  logic [3:0]             pair_last_reg;
  logic [NUM_EXT-1:0]     gnt_n_reg;
  logic [NUM_EXT-1:0]     oe_reg;
  logic                   bgnt_reg;
  logic [7:0]             req_vec;
  logic                   any_req;
  logic [2:0]             win;
  logic                   bus_idle;
  logic                   lock_seen;
  logic                   park_valid;
  logic [2:0]             park_idx;
  logic [NUM_EXT-1:0]     ext_gnt_n_next;
  logic [2:0]             idle_pick;
  logic [2:0]             win_dist;

  // Request vector; in disabled mode it is all zero, so nothing is arbitrated
  assign req_vec  = en_reg ? {bridge_req, ~ext_request_in_n} : 8'h00;
  assign bus_idle = frame_n && irdy_n;
  assign lock_seen = hold_grant_on_lock && !lock_n && !frame_n;

  pba_pick #(
    .N (8)
  ) u_pick (
    .req       (req_vec),
    .scheme    (scheme_reg),
    .order     (order_reg),
    .last      (last_reg),
    .pair_last (pair_last_reg),
    .any       (any_req),
    .win       (win)
  );

  // Parking decode: code n in 1..7 parks on requestor 7-n
  assign park_valid = (park_reg != pba_pkg::PARK_NONE) && (park_reg <= pba_pkg::PARK_BRIDGE);
  assign park_idx   = (park_reg == pba_pkg::PARK_LAST)   ? last_reg :
                      (park_reg == pba_pkg::PARK_BRIDGE) ? 3'(pba_pkg::BRIDGE_IDX) :
                      3'h7 - park_reg[2:0];

  // Idle target; a live grant to someone else must drop for a clock first
  assign idle_pick = any_req ? win : park_idx;
  // Group of the winner is half its distance below requestor 6; bridge wraps to 3
  assign win_dist  = 3'h6 - win;

  // Config is latched while idle so a mode change never splits a grant
  assign scheme_next = (priority_scheme_sel == 2'h3) ? scheme_reg : priority_scheme_sel;
  assign order_next  = priority_order_sel;
  assign park_next   = park_target_sel;

  // Grant engine: release before regrant gives one idle turnaround clock
  always_comb begin
    state_next     = state_reg;
    owner_next     = owner_reg;
    gnt_valid_next = gnt_valid_reg;
    case (state_reg)
      pba_pkg::PBA_IDLE: begin
        if (gnt_valid_reg && (any_req || park_valid) && idle_pick != owner_reg) begin
          gnt_valid_next = 1'b0;
        end else if (any_req) begin
          state_next     = pba_pkg::PBA_GRANT;
          owner_next     = win;
          gnt_valid_next = 1'b1;
        end else if (park_valid) begin
          owner_next     = park_idx;
          gnt_valid_next = 1'b1;
        end else begin
          gnt_valid_next = 1'b0;
        end
      end
      pba_pkg::PBA_GRANT: begin
        if (lock_seen) begin
          state_next = pba_pkg::PBA_LOCK;
        end else if (!req_vec[owner_reg] || (bus_idle && any_req && win != owner_reg)) begin
          state_next     = pba_pkg::PBA_IDLE;
          gnt_valid_next = 1'b0;
        end
      end
      pba_pkg::PBA_LOCK: begin
        if (lock_n && bus_idle) begin
          state_next     = pba_pkg::PBA_IDLE;
          gnt_valid_next = 1'b0;
        end
      end
      default: begin
        state_next     = pba_pkg::PBA_IDLE;
        gnt_valid_next = 1'b0;
      end
    endcase
  end

  // Decoded grants, active low
  assign ext_gnt_n_next = ~(NUM_EXT'(gnt_valid_next) << owner_next);

  // Configuration and strap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scheme_reg <= pba_pkg::SCHEME_RST;
      order_reg  <= pba_pkg::ORDER_RST;
      park_reg   <= pba_pkg::PARK_RST;
      seen_reg   <= 1'b0;
      en_reg     <= 1'b0;
    end else begin
      seen_reg <= 1'b1;
      if (!seen_reg) begin
        en_reg <= strap_enable;
      end
      if (state_reg == pba_pkg::PBA_IDLE) begin
        scheme_reg <= scheme_next;
        order_reg  <= order_next;
        park_reg   <= park_next;
      end
    end
  end

  // Grant state and history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= pba_pkg::PBA_IDLE;
      owner_reg     <= 3'h7;
      gnt_valid_reg <= 1'b0;
      last_reg      <= 3'h7;
      pair_last_reg <= 4'h0;
    end else begin
      state_reg     <= state_next;
      owner_reg     <= owner_next;
      gnt_valid_reg <= gnt_valid_next;
      // History moves only on a real grant, never during the handover gap
      if (state_reg == pba_pkg::PBA_IDLE && state_next == pba_pkg::PBA_GRANT) begin
        last_reg <= win;
        pair_last_reg[win_dist[2:1]] <= ~win[0];
      end
    end
  end

  // Pins: float in reset; disabled mode turns pin 0 into bridge request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gnt_n_reg <= '1;
      oe_reg    <= '0;
      bgnt_reg  <= 1'b0;
    end else if (!seen_reg) begin
      gnt_n_reg <= '1;
      oe_reg    <= '0;
      bgnt_reg  <= 1'b0;
    end else if (en_reg) begin
      gnt_n_reg <= ext_gnt_n_next;
      oe_reg    <= '1;
      bgnt_reg  <= gnt_valid_next && owner_next == 3'(pba_pkg::BRIDGE_IDX);
    end else begin
      gnt_n_reg <= {{(NUM_EXT-1){1'b1}}, ~bridge_req};
      oe_reg    <= NUM_EXT'(1);
      bgnt_reg  <= !ext_request_in_n[0];
    end
  end

  assign ext_grant_out_n = gnt_n_reg;
  assign ext_grant_oe    = oe_reg;
  assign bridge_gnt      = bgnt_reg;
  assign arb_enabled     = en_reg;

  // Checks
  chk_one_grant: assert property (@(posedge clk) disable iff (!rst_n)
    $countones({bgnt_reg && en_reg, ~gnt_n_reg & {NUM_EXT{en_reg}}}) <= 1)
    else $error("more than one grant");
  sequence lock_taken_s;
    state_reg == pba_pkg::PBA_LOCK && !lock_n;
  endsequence
  chk_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
    lock_taken_s |=> state_reg == pba_pkg::PBA_LOCK && $stable(owner_reg))
    else $error("lock grant dropped");
  chk_nolock_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !hold_grant_on_lock && state_reg != pba_pkg::PBA_LOCK |=> state_reg != pba_pkg::PBA_LOCK)
    else $error("lock held while disabled");
  chk_reset_cfg: assert property (@(posedge clk)
    !rst_n |=> scheme_reg == pba_pkg::SCHEME_RST && order_reg == 3'h0 && park_reg == 4'h8)
    else $error("bad reset config");
  chk_reset_float: assert property (@(posedge clk)
    !rst_n |=> oe_reg == '0)
    else $error("grant driven in reset");
  chk_gap_regrant: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == pba_pkg::PBA_GRANT && state_next == pba_pkg::PBA_IDLE |=> !gnt_valid_reg)
    else $error("grant moved without gap");
  // Two idle clocks allow for the gap when the old park owner differs
  sequence park_bridge_s;
    state_reg == pba_pkg::PBA_IDLE && !any_req && park_reg == pba_pkg::PARK_BRIDGE;
  endsequence
  chk_park_bridge: assert property (@(posedge clk) disable iff (!rst_n)
    park_bridge_s [*2] |=> owner_reg == 3'h7 && gnt_valid_reg)
    else $error("park not on bridge");
  chk_owner_gap: assert property (@(posedge clk) disable iff (!rst_n)
    gnt_valid_reg |=> !gnt_valid_reg || $stable(owner_reg))
    else $error("owner changed under grant");
  chk_park_none: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == pba_pkg::PBA_IDLE && !any_req && park_reg == pba_pkg::PARK_NONE |=> !gnt_valid_reg)
    else $error("parked while disabled");
  chk_strap_hold: assert property (@(posedge clk) disable iff (!rst_n)
    seen_reg |=> $stable(en_reg))
    else $error("enable changed after reset");
endmodule // pba_arbiter

// ==== dv/pba_ext_masters.sv ====
`timescale 1ns/1ps
// Seven external masters on their request/grant pins
module pba_ext_masters (
  input  wire logic [6:0] want,
  input  wire logic [6:0] gnt_n,
  input  wire logic [6:0] oe,
  output logic      [6:0] req_n,
  output logic      [6:0] granted
);
  // Requests follow the bench, which moves them on the falling edge
  assign req_n = ~want;
  // A floated grant pin is pulled up, so it never reads as granted
  assign granted = oe & ~gnt_n;
endmodule // pba_ext_masters

// ==== dv/pba_arbiter_tb.sv ====
`timescale 1ns/1ps
module pba_arbiter_tb;
  logic       clk     = 1'b0;
  logic       rst_n   = 1'b0;
  logic       strap   = 1'b1;
  logic [1:0] sch     = pba_pkg::SCHEME_FIXED;
  logic [2:0] ord     = 3'h0;
  logic [3:0] park    = pba_pkg::PARK_RST;
  logic       hold    = 1'b0;
  logic       frame_n = 1'b1;
  logic       irdy_n  = 1'b1;
  logic       lock_n  = 1'b1;
  logic [7:0] want    = 8'h00;
  logic [7:0] seen;
  logic [3:0] seq [8];
  logic [3:0] e;
  logic [6:0] req_n, gnt_n, oe, granted;
  logic       bgnt, en;
  int         mismatches   = 0;
  int         total_checks = 0;

  always #25 clk = ~clk;

  // Seven external pairs plus the bridge master
  pba_arbiter #(.NUM_EXT(7)) dut_u (.clk(clk), .rst_n(rst_n), .strap_enable(strap),
    .priority_scheme_sel(sch), .priority_order_sel(ord), .park_target_sel(park),
    .hold_grant_on_lock(hold), .ext_request_in_n(req_n), .ext_grant_out_n(gnt_n),
    .ext_grant_oe(oe), .bridge_req(want[7]), .bridge_gnt(bgnt), .frame_n(frame_n),
    .irdy_n(irdy_n), .lock_n(lock_n), .arb_enabled(en));
  pba_ext_masters ext_u (.want(want[6:0]), .gnt_n(gnt_n), .oe(oe), .req_n(req_n), .granted(granted));

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic fail(string m);
    mismatches++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic cmp(logic [7:0] got, logic [7:0] exp, string m);
    total_checks++;
    if (got !== exp) fail(m);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // Index of the granted requestor, 8 when none
  function automatic logic [3:0] gidx();
    gidx = (bgnt === 1'b1) ? 4'h7 : 4'h8;
    for (int i = 0; i < 7; i++) if (granted[i] === 1'b1) gidx = i[3:0];
  endfunction
  function automatic logic [7:0] fx(int j);
    fx = (j % 8 == 7) ? 8'h07 : 8'(6 - j % 8);
  endfunction
  function automatic logic [7:0] grp(logic [3:0] g);
    grp = (g == 4'h7) ? 8'h03 : 8'((6 - g) / 2);
  endfunction
  // Bounded wait until the grant is (or leaves) v
  task automatic wait_g(logic [3:0] v, bit eq);
    int k;
    k = 0;
    while ((gidx() == v) != eq) begin
      @(negedge clk);
      k++;
      if (k > 40) begin
        fail("grant wait timed out");
        end_sim();
      end
    end
  endtask
  // Owner drops its request as it starts a frame; rereq raises it again
  task automatic serve(logic [7:0] m, int n, bit rereq);
    logic [3:0] g;
    seen = 8'h00;
    // Idle clocks first so a new scheme or order is latched before requests
    cyc(2);
    want = m;
    for (int k = 0; k < n; k++) begin
      wait_g(4'h8, 1'b0);
      g = gidx();
      seq[k] = g;
      seen[g[2:0]] = 1'b1;
      frame_n = 1'b0;
      want[g[2:0]] = 1'b0;
      wait_g(g, 1'b0);
      frame_n = 1'b1;
      if (rereq) want[g[2:0]] = 1'b1;
    end
    want = 8'h00;
    cyc(4);
  endtask

  // More than one grant would let two masters fight for the bus
  always @(negedge clk) begin
    if (rst_n && en === 1'b1 && $countones({bgnt, granted}) > 1) fail("two grants");
  end

  initial begin
    cyc(16);
    cmp({1'b0, oe}, 8'h00, "oe in reset");
    cmp({bgnt, gnt_n}, 8'h7f, "grants in reset");
    rst_n = 1'b1;
    cyc(3);
    cmp({7'h0, en}, 8'h01, "strap high");
    cmp({4'h0, gidx()}, 8'h07, "park bridge");
    park = pba_pkg::PARK_NONE; // Test only: no idle driver
    cyc(3);
    cmp({4'h0, gidx()}, 8'h08, "park none");
    // Every order value, all eight competing
    for (int o = 0; o < 8; o++) begin
      ord = o[2:0];
      serve(8'hff, 8, 1'b0);
      for (int k = 0; k < 8; k++) cmp({4'h0, seq[k]}, fx(8 - o + k), "fixed");
    end
    // Mixed order kept at or below 011
    sch = pba_pkg::SCHEME_MIXED;
    for (int o = 0; o < 4; o++) begin
      ord = o[2:0];
      serve(8'hff, 8, 1'b0);
      for (int k = 0; k < 8; k++) cmp(grp(seq[k]), 8'((4 - o + k / 2) % 4), "mixed");
    end
    serve(8'h60, 2, 1'b1);
    cmp(seen, 8'h60, "pair alternation");
    sch = pba_pkg::SCHEME_RR;
    ord = 3'h5;
    serve(8'hff, 8, 1'b1);
    cmp(seen, 8'hff, "round robin");
    sch = pba_pkg::SCHEME_FIXED;
    // Only documented park codes are driven
    for (int c = 1; c < 9; c++) begin
      park = c[3:0];
      e = (c == 8) ? 4'h7 : 4'(7 - c);
      cyc(4);
      cmp({4'h0, gidx()}, {4'h0, e}, "park code");
    end
    park = pba_pkg::PARK_NONE;
    serve(8'h08, 1, 1'b0);
    park = pba_pkg::PARK_LAST;
    cyc(4);
    cmp({4'h0, gidx()}, 8'h03, "park last");
    park = pba_pkg::PARK_NONE;
    cyc(4);
    // Locked frame by 3, then 6 asks while 3 lets go
    for (int h = 0; h < 2; h++) begin
      hold = h[0];
      want = 8'h08;
      wait_g(4'h3, 1'b1);
      frame_n = 1'b0;
      irdy_n = 1'b0;
      lock_n = 1'b0;
      cyc(1);
      want = 8'h40;
      cyc(6);
      cmp({4'h0, gidx()}, h ? 8'h03 : 8'h06, "lock hold");
      frame_n = 1'b1;
      lock_n = 1'b1;
      // Last data phase still open: bus not idle, lock grant must stay
      cyc(2);
      cmp({4'h0, gidx()}, h ? 8'h03 : 8'h06, "irdy keeps bus busy");
      irdy_n = 1'b1;
      wait_g(4'h6, 1'b1);
      want = 8'h00;
      cyc(4);
    end
    // Second reset with the strap low: pin 0 pair serves the bridge
    rst_n = 1'b0;
    strap = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    cmp({7'h0, en}, 8'h00, "strap low");
    want = 8'h81;
    cyc(3);
    cmp({6'h0, bgnt, gnt_n[0]}, 8'h02, "bridge via pin 0");
    want = 8'h00;
    cyc(3);
    cmp({6'h0, bgnt, gnt_n[0]}, 8'h01, "bridge idle pin 0");
    end_sim();
  end
endmodule // pba_arbiter_tb
